/* File: verilog/qrc_regs.sv */
// Control register bank of a four-channel receiver.
// Assumes a host that issues one-cycle write and read strobes on i_clk_sys.
`timescale 1ns/1ps
module qrc_regs #(
	parameter int W = 11
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_reset, // async reset, active high
	input wire logic i_soft_reset, // sync reload of defaults
	input wire logic i_wr_en, // register write strobe
	input wire logic i_rd_en, // register read strobe
	input wire logic [7:0] i_addr, // register address
	input wire logic [7:0] i_wdata, // write data
	output logic [7:0] o_rdata, // read data
	output logic o_rd_valid, // read data pulse
	input wire logic i_pdn_pin, // external power-down pin
	input wire logic [3:0][W-1:0] i_sample, // converted samples
	output logic [3:0][W-1:0] o_data, // output words
	output logic o_data_valid, // output word pulse
	output logic o_out_en_ab, // port A/B enable
	output logic o_out_en_cd, // port C/D enable
	output logic [3:0] o_pwr_down, // channel full power-down
	output logic [3:0] o_standby, // channel standby
	output logic [3:0] o_shuffle_en, // channel shuffle on
	output logic [3:0] o_self_test_start, // self check running
	output logic [3:0] o_self_test_hold // self check in reset
);
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_APPLY = 2'b10} qrc_xfer_t;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic qrc_pkg::qrc_chan_cfg_t cfg_write(qrc_pkg::qrc_chan_cfg_t c,
		logic [7:0] a, logic [7:0] d);
		qrc_pkg::qrc_chan_cfg_t n;
		n = c;
		case (a)
			qrc_pkg::ADDR_POWER: n.power = d[1:0];
			qrc_pkg::ADDR_SHUFFLE: n.shuffle = d[1:0];
			qrc_pkg::ADDR_TEST:
			begin
				n.tmode = d[2:0];
				n.short_run = d[qrc_pkg::TEST_SHORT_RUN];
				n.long_run = d[qrc_pkg::TEST_LONG_RUN];
			end
			qrc_pkg::ADDR_SELFTEST:
			begin
				n.st_run = d[qrc_pkg::ST_RUN];
				n.st_start = d[qrc_pkg::ST_START];
			end
			default: n = c;
		endcase
		return n;
	endfunction : cfg_write

	function automatic logic [7:0] cfg_read(qrc_pkg::qrc_chan_cfg_t c,
		qrc_pkg::qrc_glob_cfg_t g, logic [7:0] sel, logic xfer, logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			qrc_pkg::ADDR_CHAN_SEL: r = sel;
			qrc_pkg::ADDR_POWER: r = {2'h0, g.pin_stby, 3'h0, c.power};
			qrc_pkg::ADDR_CLKDIV: r = {2'h0, g.phase, g.ratio};
			qrc_pkg::ADDR_SHUFFLE: r = {6'h00, c.shuffle};
			qrc_pkg::ADDR_TEST: r = {2'h0, c.long_run, c.short_run, 1'b0, c.tmode};
			qrc_pkg::ADDR_SELFTEST: r = {5'h00, c.st_run, 1'b0, c.st_start};
			qrc_pkg::ADDR_XFER: r = {7'h00, xfer};
			default: r = 8'h00;
		endcase
		return r;
	endfunction : cfg_read

	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	qrc_pkg::qrc_chan_cfg_t [3:0] sh_q, sh_d, act_q, act_d;
	qrc_pkg::qrc_glob_cfg_t gsh_q, gsh_d, gact_q, gact_d;
	logic [7:0] sel_q, sel_d;
	qrc_xfer_t st_q, st_d;
	logic [7:0] rdata_d;
	logic rd_valid_d;
	logic [1:0] rch;
	logic wr_sh;

	always_comb
	begin
		sh_d = sh_q;
		act_d = act_q;
		gsh_d = gsh_q;
		gact_d = gact_q;
		sel_d = sel_q;
		st_d = st_q;
		wr_sh = i_wr_en && i_addr >= qrc_pkg::SHADOW_LO && i_addr <= qrc_pkg::SHADOW_HI;
		case (st_q)
			ST_IDLE:
				if (i_wr_en && i_addr == qrc_pkg::ADDR_XFER && i_wdata[qrc_pkg::XFER_BIT])
					st_d = ST_APPLY;
			ST_APPLY:
			begin
				act_d = sh_q;
				gact_d = gsh_q;
				st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
		if (i_wr_en && i_addr == qrc_pkg::ADDR_CHAN_SEL)
			sel_d = i_wdata & qrc_pkg::CHAN_SEL_MASK;
		if (i_wr_en && i_addr == qrc_pkg::ADDR_POWER)
			gsh_d.pin_stby = i_wdata[qrc_pkg::PWR_PIN_FN];
		if (i_wr_en && i_addr == qrc_pkg::ADDR_CLKDIV)
		begin
			gsh_d.ratio = i_wdata[2:0];
			gsh_d.phase = i_wdata[qrc_pkg::DIV_PHASE_LSB +: 3];
		end
		for (int c = 0; c < 4; c++)
			if (wr_sh && sel_q[c])
				sh_d[c] = cfg_write(sh_q[c], i_addr, i_wdata);
		if (i_soft_reset)
		begin
			sh_d = {4{qrc_pkg::CHAN_CFG_RST}};
			act_d = {4{qrc_pkg::CHAN_CFG_RST}};
			gsh_d = qrc_pkg::GLOB_CFG_RST;
			gact_d = qrc_pkg::GLOB_CFG_RST;
			sel_d = qrc_pkg::CHAN_SEL_RST;
			st_d = ST_IDLE;
		end
		// Channel 0 whenever several channels or none are selected
		case (sel_q[3:0])
			4'h2: rch = 2'd1;
			4'h4: rch = 2'd2;
			4'h8: rch = 2'd3;
			default: rch = 2'd0;
		endcase
		rd_valid_d = i_rd_en;
		rdata_d = o_rdata;
		if (i_rd_en)
			rdata_d = cfg_read(sh_q[rch], gsh_q, sel_q, st_q == ST_APPLY, i_addr);
	end

	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			sh_q <= {4{qrc_pkg::CHAN_CFG_RST}};
			act_q <= {4{qrc_pkg::CHAN_CFG_RST}};
			gsh_q <= qrc_pkg::GLOB_CFG_RST;
			gact_q <= qrc_pkg::GLOB_CFG_RST;
			sel_q <= qrc_pkg::CHAN_SEL_RST;
			st_q <= ST_IDLE;
			o_rdata <= 8'h00;
			o_rd_valid <= 1'b0;
		end
		else
		begin
			sh_q <= sh_d;
			act_q <= act_d;
			gsh_q <= gsh_d;
			gact_q <= gact_d;
			sel_q <= sel_d;
			st_q <= st_d;
			o_rdata <= rdata_d;
			o_rd_valid <= rd_valid_d;
		end
	end

	// ----------------------------------------
	// Pin synchroniser and sample tick
	// ----------------------------------------
	logic [2:0] pin_q;
	logic pin_lvl_q, samp_en;

	// Level moves only once stages two and three agree
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			pin_q <= 3'h0;
			pin_lvl_q <= 1'b0;
		end
		else
		begin
			pin_q <= {pin_q[1:0], i_pdn_pin};
			if (pin_q[1] == pin_q[2])
				pin_lvl_q <= pin_q[2];
		end
	end

	qrc_clkdiv u_div (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_ratio(gact_q.ratio),
		.i_phase(gact_q.phase),
		.o_tick(samp_en)
	);

	// ----------------------------------------
	// Pattern generators
	// ----------------------------------------
	logic [3:0][W-1:0] lw, sw;

	for (genvar c = 0; c < 4; c++)
	begin : g_gen
		qrc_prbs #(.LEN(qrc_pkg::LONG_LEN), .TAP(qrc_pkg::LONG_TAP), .W(W)) u_long (
			.i_clk_sys(i_clk_sys),
			.i_reset(i_reset),
			.i_hold(!act_q[c].long_run),
			.i_step(samp_en),
			.o_word(lw[c])
		);
		qrc_prbs #(.LEN(qrc_pkg::SHORT_LEN), .TAP(qrc_pkg::SHORT_TAP), .W(W)) u_short (
			.i_clk_sys(i_clk_sys),
			.i_reset(i_reset),
			.i_hold(!act_q[c].short_run),
			.i_step(samp_en),
			.o_word(sw[c])
		);
	end

	// ----------------------------------------
	// Channel outputs
	// ----------------------------------------
	localparam logic [W-1:0] MID = W'(1) << (W - 1);
	// Pair pattern is one bit wider for odd W; cut to W on purpose
	localparam logic [W-1:0] CHECKER = W'({(W + 1) / 2{2'b01}});
	logic [3:0][W-1:0] data_d;
	logic [3:0] tog_q, tog_d, pd_d, sb_d;
	logic data_valid_d;

	always_comb
	begin
		data_d = o_data;
		tog_d = tog_q;
		data_valid_d = samp_en;
		for (int c = 0; c < 4; c++)
		begin
			pd_d[c] = act_q[c].power == qrc_pkg::PM_OFF
				|| (pin_lvl_q && !gact_q.pin_stby);
			sb_d[c] = !pd_d[c] && (act_q[c].power == qrc_pkg::PM_STBY
				|| (pin_lvl_q && gact_q.pin_stby));
			if (samp_en)
			begin
				tog_d[c] = !tog_q[c];
				case (act_q[c].tmode)
					qrc_pkg::TM_OFF: data_d[c] = i_sample[c];
					qrc_pkg::TM_MID: data_d[c] = MID;
					qrc_pkg::TM_POS_FS: data_d[c] = '1;
					qrc_pkg::TM_NEG_FS: data_d[c] = '0;
					qrc_pkg::TM_CHECKER: data_d[c] = tog_q[c] ? ~CHECKER : CHECKER;
					qrc_pkg::TM_LONG: data_d[c] = lw[c];
					qrc_pkg::TM_SHORT: data_d[c] = sw[c];
					default: data_d[c] = {W{tog_q[c]}};
				endcase
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_data <= '0;
			o_data_valid <= 1'b0;
			tog_q <= 4'h0;
			o_pwr_down <= 4'h0;
			o_standby <= 4'h0;
			o_shuffle_en <= 4'h0;
			o_self_test_start <= 4'h0;
			o_self_test_hold <= 4'h0;
		end
		else
		begin
			o_data <= data_d;
			o_data_valid <= data_valid_d;
			tog_q <= tog_d;
			o_pwr_down <= pd_d;
			o_standby <= sb_d;
			for (int c = 0; c < 4; c++)
			begin
				o_shuffle_en[c] <= act_q[c].shuffle == qrc_pkg::SH_ON;
				o_self_test_start[c] <= act_q[c].st_start && act_q[c].st_run;
				o_self_test_hold[c] <= !act_q[c].st_run;
			end
		end
	end

	assign o_out_en_ab = sel_q[qrc_pkg::CS_OUT_AB];
	assign o_out_en_cd = sel_q[qrc_pkg::CS_OUT_CD];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	property p_steer;
		i_wr_en && i_addr == qrc_pkg::ADDR_POWER && !sel_q[0] && !i_soft_reset
			|=> sh_q[0] == $past(sh_q[0]);
	endproperty
	a_steer: assert property (p_steer) else $error("unselected channel written");

	property p_sel_default;
		i_soft_reset |=> sel_q == qrc_pkg::CHAN_SEL_RST && o_out_en_ab && o_out_en_cd;
	endproperty
	a_sel_default: assert property (p_sel_default) else $error("select default wrong");

	property p_off;
		act_q[0].power == qrc_pkg::PM_OFF |=> o_pwr_down[0] && !o_standby[0];
	endproperty
	a_off: assert property (p_off) else $error("power-down not applied");

	property p_pin_stby;
		pin_lvl_q && gact_q.pin_stby && act_q[0].power == 2'h0
			|=> o_standby[0] && !o_pwr_down[0];
	endproperty
	a_pin_stby: assert property (p_pin_stby) else $error("pin standby wrong");

	property p_div2;
		samp_en && gact_q.ratio == 3'h1 && $stable(gact_q) && st_q == ST_IDLE && !i_wr_en
			|=> !samp_en ##1 samp_en;
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two spacing wrong");

	property p_pos_fs;
		samp_en && act_q[0].tmode == qrc_pkg::TM_POS_FS |=> o_data[0] == '1 && o_data_valid;
	endproperty
	a_pos_fs: assert property (p_pos_fs) else $error("positive full-scale missing");

	property p_normal;
		samp_en && act_q[1].tmode == qrc_pkg::TM_OFF |=> o_data[1] == $past(i_sample[1]);
	endproperty
	a_normal: assert property (p_normal) else $error("sample not passed");

	property p_short_hold;
		!act_q[0].short_run |=> sw[0] == '1;
	endproperty
	a_short_hold: assert property (p_short_hold) else $error("short generator not held");

	property p_apply;
		st_q == ST_IDLE && i_wr_en && i_addr == qrc_pkg::ADDR_XFER && i_wdata[0] && !i_soft_reset
			|=> st_q == ST_APPLY ##1 st_q == ST_IDLE && act_q[0] == $past(sh_q[0]);
	endproperty
	a_apply: assert property (p_apply) else $error("transfer not applied once");

	property p_read_a;
		i_rd_en && sel_q[3:0] == 4'hF && i_addr == qrc_pkg::ADDR_SHUFFLE
			|=> o_rd_valid && o_rdata == {6'h00, $past(sh_q[0].shuffle)};
	endproperty
	a_read_a: assert property (p_read_a) else $error("multi-select read not channel A");

	c_apply: cover property (st_q == ST_APPLY);
	c_long: cover property (samp_en && act_q[0].tmode == qrc_pkg::TM_LONG && act_q[0].long_run);
	c_pin: cover property (pin_lvl_q && o_standby[2]);

endmodule : qrc_regs

/* File: verilog/qrc_pkg.sv */
// Constants and types of the quad receiver control register bank.
// Assumes an 8-bit address / 8-bit data register port from the serial host.
package qrc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CHAN_SEL = 8'h05;
	localparam logic [7:0] ADDR_POWER = 8'h08;
	localparam logic [7:0] ADDR_CLKDIV = 8'h0B;
	localparam logic [7:0] ADDR_SHUFFLE = 8'h0C;
	localparam logic [7:0] ADDR_TEST = 8'h0D;
	localparam logic [7:0] ADDR_SELFTEST = 8'h0E;
	localparam logic [7:0] ADDR_XFER = 8'hFF;
	localparam logic [7:0] SHADOW_LO = 8'h08;
	localparam logic [7:0] SHADOW_HI = 8'h3E;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CS_OUT_CD = 7;
	localparam int CS_OUT_AB = 6;
	localparam int PWR_PIN_FN = 5;
	localparam int DIV_PHASE_LSB = 3;
	localparam int TEST_LONG_RUN = 5;
	localparam int TEST_SHORT_RUN = 4;
	localparam int ST_RUN = 2;
	localparam int ST_START = 0;
	localparam int XFER_BIT = 0;

	// ----------------------------------------
	// Reset values and masks
	// ----------------------------------------
	localparam logic [7:0] CHAN_SEL_RST = 8'hCF;
	localparam logic [7:0] CHAN_SEL_MASK = 8'hCF;
	localparam logic [7:0] POWER_RST = 8'h00;
	localparam logic [7:0] CLKDIV_RST = 8'h00;
	localparam logic [7:0] SHUFFLE_RST = 8'h01;
	localparam logic [7:0] TEST_RST = 8'h00;
	localparam logic [7:0] SELFTEST_RST = 8'h00;

	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [1:0] PM_OFF = 2'h1;
	localparam logic [1:0] PM_STBY = 2'h2;
	localparam logic [1:0] SH_ON = 2'h1;
	localparam logic [2:0] TM_OFF = 3'h0;
	localparam logic [2:0] TM_MID = 3'h1;
	localparam logic [2:0] TM_POS_FS = 3'h2;
	localparam logic [2:0] TM_NEG_FS = 3'h3;
	localparam logic [2:0] TM_CHECKER = 3'h4;
	localparam logic [2:0] TM_LONG = 3'h5;
	localparam logic [2:0] TM_SHORT = 3'h6;
	localparam logic [2:0] TM_TOGGLE = 3'h7;

	// ----------------------------------------
	// Pattern generators and divider
	// ----------------------------------------
	localparam int LONG_LEN = 23;
	localparam int LONG_TAP = 18;
	localparam int SHORT_LEN = 9;
	localparam int SHORT_TAP = 5;
	localparam int DIV_MAX = 8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] power;
		logic [1:0] shuffle;
		logic long_run;
		logic short_run;
		logic [2:0] tmode;
		logic st_run;
		logic st_start;
	} qrc_chan_cfg_t;

	typedef struct packed {
		logic pin_stby;
		logic [2:0] phase;
		logic [2:0] ratio;
	} qrc_glob_cfg_t;

	localparam qrc_chan_cfg_t CHAN_CFG_RST = '{
		power: POWER_RST[1:0], shuffle: SHUFFLE_RST[1:0],
		long_run: TEST_RST[TEST_LONG_RUN], short_run: TEST_RST[TEST_SHORT_RUN],
		tmode: TEST_RST[2:0], st_run: SELFTEST_RST[ST_RUN], st_start: SELFTEST_RST[ST_START]};
	localparam qrc_glob_cfg_t GLOB_CFG_RST = '{
		pin_stby: POWER_RST[PWR_PIN_FN], phase: CLKDIV_RST[5:3], ratio: CLKDIV_RST[2:0]};

endpackage : qrc_pkg

/* File: verilog/qrc_clkdiv.sv */
// Integer divider of the input clock into a one-cycle sample tick.
// Assumes ratio and phase come from registered configuration.
`timescale 1ns/1ps
module qrc_clkdiv #(
	parameter int MAX = qrc_pkg::DIV_MAX
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_reset, // async reset, active high
	input wire logic [2:0] i_ratio, // divide by ratio + 1
	input wire logic [2:0] i_phase, // delay in input cycles
	output logic o_tick // sample tick pulse
);
	logic [2:0] cnt_q, cnt_d;
	logic [MAX-2:0] dly_q, dly_d;
	logic base;
	logic [MAX-1:0] taps;

	always_comb
	begin
		base = (cnt_q == 3'h0);
		cnt_d = (cnt_q >= i_ratio) ? 3'h0 : cnt_q + 3'h1;
		dly_d = {dly_q[MAX-3:0], base};
		taps = {dly_q, base};
	end

	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			cnt_q <= 3'h0;
			dly_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_d;
			dly_q <= dly_d;
		end
	end

	assign o_tick = taps[i_phase];

endmodule : qrc_clkdiv

/* File: verilog/qrc_prbs.sv */
// Pseudo-random pattern generator, one output word per step.
// Assumes the hold input is a registered control level.
`timescale 1ns/1ps
module qrc_prbs #(
	parameter int LEN = qrc_pkg::LONG_LEN,
	parameter int TAP = qrc_pkg::LONG_TAP,
	parameter int W = 11
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_reset, // async reset, active high
	input wire logic i_hold, // hold at seed
	input wire logic i_step, // advance one bit
	output logic [W-1:0] o_word // pattern word
);
	logic [LEN-1:0] lfsr_q, lfsr_d;

	always_comb
	begin
		lfsr_d = lfsr_q;
		if (i_hold)
			lfsr_d = '1;
		else if (i_step)
			lfsr_d = {lfsr_q[LEN-2:0], lfsr_q[LEN-1] ^ lfsr_q[TAP-1]};
		for (int i = 0; i < W; i++)
			o_word[i] = lfsr_q[i % LEN];
	end

	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
			lfsr_q <= '1;
		else
			lfsr_q <= lfsr_d;
	end

endmodule : qrc_prbs

/* File: verification/qrc_host_model.sv */
// Serial host model: one-cycle register strobes launched on the falling edge.
// Assumes the bank answers a read with a one-cycle valid pulse a cycle later.
`timescale 1ns/1ps
module qrc_host_model (
	input wire logic i_clk_sys, // system clock
	output logic o_wr_en, // write strobe
	output logic o_rd_en, // read strobe
	output logic [7:0] o_addr, // register address
	output logic [7:0] o_wdata, // write data
	input wire logic [7:0] i_rdata, // read data
	input wire logic i_rd_valid // read data pulse
);
	initial
	begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk_sys);
		o_wr_en = 1'b1;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk_sys);
		o_wr_en = 1'b0;
		// Idle bus shows a changed pattern, so stale values cannot pass
		o_addr = ~a;
		o_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(negedge i_clk_sys);
		o_rd_en = 1'b1;
		o_addr = a;
		@(negedge i_clk_sys);
		o_rd_en = 1'b0;
		o_addr = ~a;
		d = 8'hXX;
		for (n = 0; n < 4 && i_rd_valid !== 1'b1; n++)
			@(negedge i_clk_sys);
		if (i_rd_valid === 1'b1)
			d = i_rdata;
	endtask : rd

	// Apply code, then wait until the new configuration reaches the outputs
	task automatic apply();
		wr(8'hFF, 8'h01);
		repeat (4) @(negedge i_clk_sys);
	endtask : apply
endmodule : qrc_host_model

/* File: verification/qrc_regs_tb_top.sv */
// Self-checking bench of the receiver control register bank.
// Assumes the host model file is compiled first; stimulus on falling edges.
`timescale 1ns/1ps
module qrc_regs_tb_top;
	localparam int W = 11;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [1:0] kind; logic [15:0] exp;} qrc_row_t;
	logic i_clk_sys = 1'b0;
	logic i_reset = 1'b1;
	logic i_soft_reset = 1'b0;
	logic i_pdn_pin = 1'b0;
	logic [3:0][W-1:0] i_sample = {11'h321, 11'h2BC, 11'h0F0, 11'h123};
	logic i_wr_en, i_rd_en, o_rd_valid, o_data_valid, o_out_en_ab, o_out_en_cd;
	logic [7:0] i_addr, i_wdata, o_rdata, rv;
	logic [3:0][W-1:0] o_data;
	logic [3:0] o_pwr_down, o_standby, o_shuffle_en, o_self_test_start, o_self_test_hold;
	logic [W-1:0] w0, w1;
	logic [7:0] alt[4] = '{8'h04, 8'h07, 8'h16, 8'h25};
	int bad_count = 0;
	int check_count = 0;
	int g;
	time t0;
	// Kind 0 read, 1 write then read back, 2 test code applied then output word
	qrc_row_t rows[21] = '{
		'{8'h05, 8'h00, 2'h0, 16'h00CF}, '{8'h08, 8'h00, 2'h0, 16'h0000},
		'{8'h0B, 8'h00, 2'h0, 16'h0000}, '{8'h0C, 8'h00, 2'h0, 16'h0001},
		'{8'h0D, 8'h00, 2'h0, 16'h0000}, '{8'h0E, 8'h00, 2'h0, 16'h0000},
		'{8'hFF, 8'h00, 2'h0, 16'h0000}, '{8'h13, 8'h00, 2'h0, 16'h0000},
		'{8'h0D, 8'h00, 2'h2, 16'h0123}, '{8'h0D, 8'h01, 2'h2, 16'h0400},
		'{8'h0D, 8'h02, 2'h2, 16'h07FF}, '{8'h0D, 8'h03, 2'h2, 16'h0000},
		'{8'h0D, 8'h05, 2'h2, 16'h07FF}, '{8'h0D, 8'h06, 2'h2, 16'h07FF},
		'{8'h08, 8'hFF, 2'h1, 16'h0023}, '{8'h0B, 8'hFF, 2'h1, 16'h003F},
		'{8'h0C, 8'hFF, 2'h1, 16'h0003}, '{8'h0D, 8'hFF, 2'h1, 16'h0037},
		'{8'h0E, 8'hFF, 2'h1, 16'h0005}, '{8'h13, 8'hAA, 2'h1, 16'h0000},
		'{8'h05, 8'hFF, 2'h1, 16'h00CF}};

	always #5 i_clk_sys = ~i_clk_sys;

	qrc_regs #(.W(W)) i_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_soft_reset(i_soft_reset), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
		.i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .i_pdn_pin(i_pdn_pin),
		.i_sample(i_sample), .o_data(o_data), .o_data_valid(o_data_valid),
		.o_out_en_ab(o_out_en_ab), .o_out_en_cd(o_out_en_cd), .o_pwr_down(o_pwr_down),
		.o_standby(o_standby), .o_shuffle_en(o_shuffle_en),
		.o_self_test_start(o_self_test_start), .o_self_test_hold(o_self_test_hold));

	qrc_host_model i_host (.i_clk_sys(i_clk_sys), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
		.o_addr(i_addr), .o_wdata(i_wdata), .i_rdata(o_rdata), .i_rd_valid(o_rd_valid));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		i_host.rd(a, rv);
		chk({8'h00, rv}, exp);
	endtask : rchk

	// Next channel A word; bounded wait for the data pulse
	task automatic word(output logic [W-1:0] w);
		int n;
		@(negedge i_clk_sys);
		for (n = 0; n < 20 && o_data_valid !== 1'b1; n++)
			@(negedge i_clk_sys);
		w = o_data[0];
	endtask : word

	initial
	begin
		#200000;
		bad_count++;
		give_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(negedge i_clk_sys);
		i_reset = 1'b0;
		@(negedge i_clk_sys);
		chk({o_out_en_cd, o_out_en_ab, o_shuffle_en}, 16'h003F);
		foreach (rows[k])
		begin
			if (rows[k].kind != 2'h0)
				i_host.wr(rows[k].a, rows[k].d);
			if (rows[k].kind == 2'h2)
			begin
				i_host.apply();
				word(w0);
				chk({5'h00, w0}, rows[k].exp);
			end
			else
				rchk(rows[k].a, rows[k].exp);
		end
		@(negedge i_clk_sys);
		i_soft_reset = 1'b1;
		@(negedge i_clk_sys);
		i_soft_reset = 1'b0;
		rchk(8'h0D, 16'h0000);
		rchk(8'h0C, 16'h0001);
		foreach (alt[k])
		begin
			i_host.wr(8'h0D, alt[k]);
			i_host.apply();
			word(w0);
			word(w1);
			if (k < 2)
			begin
				chk({5'h00, w0 ^ w1}, 16'h07FF);
				chk({15'h0, w0 === (k == 0 ? 11'h555 : 11'h7FF)
					|| w0 === (k == 0 ? 11'h2AA : 11'h000)}, 16'h0001);
			end
			else
				chk({15'h0, w0 !== w1}, 16'h0001);
		end
		i_host.wr(8'h05, 8'hC2);
		i_host.wr(8'h0C, 8'h00);
		chk({12'h000, o_shuffle_en}, 16'h000F);
		i_host.apply();
		chk({12'h000, o_shuffle_en}, 16'h000D);
		rchk(8'h0C, 16'h0000);
		rchk(8'hFF, 16'h0000);
		i_host.wr(8'h05, 8'hCF);
		rchk(8'h0C, 16'h0001);
		i_host.wr(8'h05, 8'hC1);
		i_host.wr(8'h08, 8'h01);
		i_host.wr(8'h05, 8'hC4);
		i_host.wr(8'h08, 8'h02);
		i_host.apply();
		chk({8'h00, o_pwr_down, o_standby}, 16'h0014);
		i_host.wr(8'h05, 8'hCF);
		i_host.wr(8'h08, 8'h00);
		i_host.apply();
		i_pdn_pin = 1'b1;
		repeat (8) @(negedge i_clk_sys);
		chk({8'h00, o_pwr_down, o_standby}, 16'h00F0);
		i_host.wr(8'h08, 8'h20);
		i_host.apply();
		chk({8'h00, o_pwr_down, o_standby}, 16'h000F);
		i_pdn_pin = 1'b0;
		i_host.wr(8'h05, 8'h4F);
		chk({14'h0, o_out_en_cd, o_out_en_ab}, 16'h0001);
		i_host.wr(8'h05, 8'h8F);
		chk({14'h0, o_out_en_cd, o_out_en_ab}, 16'h0002);
		i_host.wr(8'h05, 8'hCF);
		i_host.wr(8'h0E, 8'h05);
		i_host.apply();
		chk({8'h00, o_self_test_start, o_self_test_hold}, 16'h00F0);
		i_host.wr(8'h0E, 8'h01);
		i_host.apply();
		chk({8'h00, o_self_test_start, o_self_test_hold}, 16'h000F);
		for (int r = 0; r < 8; r++)
		begin
			i_host.wr(8'h0B, {2'b00, 3'(r), 3'(r)});
			i_host.apply();
			repeat (2) word(w0);
			for (g = 1; g < 20; g++)
			begin
				@(negedge i_clk_sys);
				if (o_data_valid === 1'b1)
					break;
			end
			chk(16'(g), 16'(r + 1));
		end
		// Phase step of 3 at divide by 8: next tick lands 8 + 3 cycles on
		i_host.wr(8'h0B, 8'h07);
		i_host.apply();
		word(w0);
		t0 = $time;
		i_host.wr(8'h0B, 8'h1F);
		i_host.apply();
		word(w1);
		chk(16'(($time - t0) / 10), 16'h000B);
		give_verdict();
	end
endmodule : qrc_regs_tb_top
